// >>> design/can_mailbox_filter_config.sv
`timescale 1ns/100ps
`include "can_mbx_defs.svh"
// Functional notes
// - Length register writes dropped while its mailbox is not empty.
// - Data byte writes dropped while the owning mailbox is not empty.
// - Send-global-time acts only in time-triggered mode; stamp ends data.
// - Length register bits 6:4 always read zero.
// - Low nibble length code gives data or requested byte count.
// - Eight data byte registers per mailbox; zero to eight bytes.
// - Start-of-frame timer low byte goes to stamp low register.
// - Start-of-frame timer high byte goes to stamp high register.
// - Accepted message goes to fifo chosen by filter fifo select bit.
// - Scale field sits at bits 6:5 odd filter, 2:1 even filter.
// - Filter on bit at 4 odd, 0 even, enables the filter.
// - Four config registers cover pairs; odd filter in upper nibble.
// - Two mode bits per filter; zero mask, one identifier list.
// - Upper mode register holds filters 7..4, high bit above low.
// - Config and mode bits change only by software; reset zero.
// - Lower mode register holds filters 3..0 in the same layout.
// - Identifier bank bit: zero dominant, one recessive expected.
// - Mask bank bit: zero ignore, one must match identifier.
// - Transmit mailbox writable only when empty; receive never writable.
module can_mailbox_filter_config #(
  parameter int NUM_MBX = 4,
  parameter int NUM_RX = 1,
  parameter int NUM_FLT = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Controller state
  input wire logic [3:0] mbx_empty,
  input wire logic init_mode,
  input wire logic time_triggered_mode,
  // Frame events from the bit engine
  input wire can_mbx_pkg::stamp_cap_t stamp_cap,
  input wire logic [1:0] tx_sel,
  // Outputs toward the protocol engine and filter datapath
  output can_mbx_pkg::tx_info_t tx_info,
  output can_mbx_pkg::filter_cfg_t [7:0] filter_cfg,
  output logic [63:0] tx_data
);
  import can_mbx_pkg::*;

  initial begin
    if (NUM_MBX != 4 || NUM_FLT != 8 || NUM_RX < 0 || NUM_RX > NUM_MBX)
      $error("can_mailbox_filter_config: unsupported parameters");
  end

  // Storage
  logic [7:0] len_q [NUM_MBX];
  logic [7:0] data_q [NUM_MBX][8];
  logic [7:0] tsl_q [NUM_MBX];
  logic [7:0] tsh_q [NUM_MBX];
  logic [7:0] cfg_q [4];
  logic [7:0] mode_lo_q;
  logic [7:0] mode_hi_q;
  logic [7:0] bank_q [NUM_FLT][8];
  logic [7:0] fault_cnt_q;

  // Write channel state
  logic aw_have_q, w_have_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [1:0] wm;
  logic [5:0] wo;
  logic mbx_wr_ok;
  logic bank_wr_ok;
  logic [2:0] bf;
  logic [2:0] br;

  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wm = awaddr_q[7:6];
  assign wo = awaddr_q[5:0];
  assign bf = awaddr_q[7:5];
  assign br = awaddr_q[4:2];
  // Receive mailboxes never writable; transmit only when empty
  assign mbx_wr_ok = (int'(wm) >= NUM_RX) && mbx_empty[wm];
  // Bank writable only with its filter switched off
  assign bank_wr_ok = !(bf[0] ? cfg_q[bf[2:1]][4] : cfg_q[bf[2:1]][0]);

  // Address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Ready flags and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid;
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready)
                      && !s_axi_bvalid;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        // Protected writes still answer OKAY
        s_axi_bresp <= wr_mapped(awaddr_q) ? `RESP_OKAY
                                           : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic wr_mapped(input logic [11:0] a);
    logic ok;
    ok = 1'b0;
    if (a[11:8] == 4'h0) begin
      ok = (a[5:0] <= `MBX_TSH_OFS) && (a[1:0] == 2'b00);
    end else if (a[11:10] == 2'b01) begin
      ok = (a[9:8] == 2'b00) && (a[1:0] == 2'b00);
    end else if (a[11:5] == `FLT_CFG0_ADDR >> 5) begin
      ok = (a[4:0] <= 5'h18) && (a[1:0] == 2'b00) && (a[4:2] != 3'h4 ||
           a[4:0] == 5'h10);
    end
    return ok;
  endfunction : wr_mapped

  // Mailbox registers: software writes and frame stamps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int m = 0; m < NUM_MBX; m++) begin
        len_q[m] <= 8'h00;
        tsl_q[m] <= 8'h00;
        tsh_q[m] <= 8'h00;
        for (int b = 0; b < 8; b++) data_q[m][b] <= 8'h00;
      end
    end else begin
      if (do_write && awaddr_q[11:8] == 4'h0 && mbx_wr_ok && wstrb_q[0])
        begin
        if (wo == `MBX_LEN_OFS)
          len_q[wm] <= wdata_q[7:0] & `LEN_KEEP_MASK;
        else if (wo >= `MBX_DATA_OFS && wo < `MBX_TSL_OFS)
          data_q[wm][3'(wo[4:2] - 3'd1)] <= wdata_q[7:0];
        else if (wo == `MBX_TSL_OFS)
          tsl_q[wm] <= wdata_q[7:0];
        else if (wo == `MBX_TSH_OFS)
          tsh_q[wm] <= wdata_q[7:0];
      end
      // One capture per frame into the mailbox holding it
      if (stamp_cap.valid) begin
        tsl_q[stamp_cap.mbx] <= stamp_cap.timer[7:0];
        tsh_q[stamp_cap.mbx] <= stamp_cap.timer[15:8];
      end
    end
  end

  // Filter configuration, mode and bank registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) cfg_q[i] <= `CFG_RESET;
      mode_lo_q <= `MODE_RESET;
      mode_hi_q <= `MODE_RESET;
      fault_cnt_q <= 8'h00;
      for (int f = 0; f < NUM_FLT; f++)
        for (int r = 0; r < 8; r++) bank_q[f][r] <= 8'h00;
    end else if (do_write && wstrb_q[0]) begin
      if (awaddr_q[11:4] == `FLT_CFG0_ADDR >> 4) begin
        // Fifo select and scale frozen outside init mode
        if (init_mode)
          cfg_q[awaddr_q[3:2]] <= wdata_q[7:0];
        else begin
          cfg_q[awaddr_q[3:2]] <= (cfg_q[awaddr_q[3:2]] & 8'hee)
                                  | (wdata_q[7:0] & 8'h11);
          if ((wdata_q[7:0] & 8'hee) != (cfg_q[awaddr_q[3:2]] & 8'hee))
            fault_cnt_q <= fault_cnt_q + 8'h01;
        end
      end else if (awaddr_q == `FLT_MODE_LO_ADDR)
        mode_lo_q <= wdata_q[7:0];
      else if (awaddr_q == `FLT_MODE_HI_ADDR)
        mode_hi_q <= wdata_q[7:0];
      else if (awaddr_q == `FLT_CTRL_ADDR)
        fault_cnt_q <= 8'h00;
      else if (awaddr_q[11:8] == `FLT_BANK_BASE >> 8) begin
        if (bank_wr_ok)
          bank_q[bf][br] <= wdata_q[7:0];
      end
    end
  end

  // Read channel
  logic [7:0] rd_byte;
  logic rd_ok;
  logic [1:0] rm;
  logic [5:0] ro;
  assign rm = s_axi_araddr[7:6];
  assign ro = s_axi_araddr[5:0];

  always_comb begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    if (s_axi_araddr[1:0] != 2'b00) rd_ok = 1'b0;
    else if (s_axi_araddr[11:8] == 4'h0) begin
      if (ro == `MBX_LEN_OFS) rd_byte = len_q[rm] & `LEN_KEEP_MASK;
      else if (ro >= `MBX_DATA_OFS && ro < `MBX_TSL_OFS)
        rd_byte = data_q[rm][3'(ro[4:2] - 3'd1)];
      else if (ro == `MBX_TSL_OFS) rd_byte = tsl_q[rm];
      else if (ro == `MBX_TSH_OFS) rd_byte = tsh_q[rm];
      else if (ro == `MBX_STAT_OFS) rd_byte = {7'h00, mbx_empty[rm]};
      else rd_ok = 1'b0;
    end else if (s_axi_araddr[11:4] == `FLT_CFG0_ADDR >> 4)
      rd_byte = cfg_q[s_axi_araddr[3:2]];
    else if (s_axi_araddr == `FLT_MODE_LO_ADDR) rd_byte = mode_lo_q;
    else if (s_axi_araddr == `FLT_MODE_HI_ADDR) rd_byte = mode_hi_q;
    else if (s_axi_araddr == `FLT_CTRL_ADDR) rd_byte = fault_cnt_q;
    else if (s_axi_araddr[11:8] == `FLT_BANK_BASE >> 8)
      rd_byte = bank_q[s_axi_araddr[7:5]][s_axi_araddr[4:2]];
    else rd_ok = 1'b0;
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Transmit view of the selected mailbox
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_info <= '0;
      tx_data <= 64'h0;
    end else begin
      tx_info.length_code <= len_q[tx_sel][`LEN_CODE_MSB:0];
      tx_info.send_global_time <= len_q[tx_sel][`LEN_SEND_GT_BIT]
                                  && time_triggered_mode;
      tx_info.stamp <= {tsh_q[tx_sel], tsl_q[tx_sel]};
      for (int b = 0; b < 8; b++) tx_data[b*8 +: 8] <= data_q[tx_sel][b];
    end
  end

  // Per-filter configuration fan-out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filter_cfg <= '0;
    end else begin
      for (int f = 0; f < 8; f++) begin
        filter_cfg[f].fifo_select_bit <= cfg_q[f/2][(f%2)*4+3];
        filter_cfg[f].scale_field <= cfg_q[f/2][(f%2)*4+1 +: 2];
        filter_cfg[f].filter_on_bit <= cfg_q[f/2][(f%2)*4];
        filter_cfg[f].high_half_mode <= (f < 4) ? mode_lo_q[(f%4)*2+1]
                                        : mode_hi_q[(f%4)*2+1];
        filter_cfg[f].low_half_mode <= (f < 4) ? mode_lo_q[(f%4)*2]
                                       : mode_hi_q[(f%4)*2];
      end
    end
  end
endmodule : can_mailbox_filter_config

// >>> design/can_mbx_defs.svh
`ifndef CAN_MBX_DEFS_SVH
`define CAN_MBX_DEFS_SVH
// Mailbox window: mailbox m at byte 0x000 + m*0x40
`define MBX_STRIDE 12'h040
`define MBX_LEN_OFS 6'h00
`define MBX_DATA_OFS 6'h04
`define MBX_TSL_OFS 6'h24
`define MBX_TSH_OFS 6'h28
`define MBX_STAT_OFS 6'h2c
// Filter block
`define FLT_CFG0_ADDR 12'h200
`define FLT_MODE_LO_ADDR 12'h210
`define FLT_MODE_HI_ADDR 12'h214
`define FLT_CTRL_ADDR 12'h218
`define FLT_BANK_BASE 12'h400
// Field positions in the length register
`define LEN_SEND_GT_BIT 7
`define LEN_CODE_MSB 3
`define LEN_KEEP_MASK 8'h8f
// Reset values
`define CFG_RESET 8'h00
`define MODE_RESET 8'h00
// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// >>> design/can_mbx_pkg.sv
package can_mbx_pkg;
  // Time stamp capture request from the bit engine
  typedef struct packed {
    logic valid;
    logic [1:0] mbx;
    logic [15:0] timer;
  } stamp_cap_t;
  // Per-filter configuration seen by the matching datapath
  typedef struct packed {
    logic fifo_select_bit;
    logic [1:0] scale_field;
    logic filter_on_bit;
    logic high_half_mode;
    logic low_half_mode;
  } filter_cfg_t;
  // Transmit request toward the protocol engine
  typedef struct packed {
    logic [3:0] length_code;
    logic send_global_time;
    logic [15:0] stamp;
  } tx_info_t;
endpackage : can_mbx_pkg

// >>> verification/can_cfg_chk.sv
`timescale 1ns/100ps
`include "can_mbx_defs.svh"
module can_cfg_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Controller side
  input wire logic time_triggered_mode,
  input wire can_mbx_pkg::tx_info_t tx_info,
  input wire can_mbx_pkg::filter_cfg_t [7:0] filter_cfg
);
  import can_mbx_pkg::*;
  logic [11:0] ar_q;
  // Address of the read in flight
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (wr_taken
    |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  AST_LEN_RSVD: assert property (s_axi_rvalid && ar_q < 12'h100 &&
    ar_q[5:0] == `MBX_LEN_OFS |-> s_axi_rdata[6:4] == 3'h0)
    else $error("length bits 6:4 set");
  AST_GT_GATE: assert property (!time_triggered_mode &&
    !$past(time_triggered_mode) |-> !tx_info.send_global_time)
    else $error("global time outside mode");
  AST_CFG_RESET: assert property ($rose(aresetn)
    |-> filter_cfg == '0) else $error("filter config not zero");
  AST_CFG_SW: assert property (!$stable(filter_cfg)
    |-> !$past(s_axi_awready)) else $error("filter config moved alone");
endmodule : can_cfg_chk
bind can_mailbox_filter_config can_cfg_chk u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .time_triggered_mode, .tx_info, .filter_cfg);

// >>> verification/can_engine_model.sv
`timescale 1ns/100ps
module can_engine_model (
  // Clock
  input wire logic aclk,
  // Toward the register block
  output logic [3:0] mbx_empty,
  output can_mbx_pkg::stamp_cap_t stamp_cap
);
  import can_mbx_pkg::*;
  // All mailboxes empty, no capture
  initial begin
    mbx_empty = 4'hf;
    stamp_cap = '0;
  end
  // Mark a mailbox empty or pending
  task automatic set_empty(input int m, input logic e);
    @(posedge aclk);
    mbx_empty[m] <= e;
  endtask : set_empty
  // One frame gives a single start-of-frame capture
  task automatic frame(input logic [1:0] m, input logic [15:0] t);
    @(posedge aclk);
    stamp_cap <= '{1'b1, m, t};
    @(posedge aclk);
    stamp_cap <= '{1'b0, ~m, ~t};
  endtask : frame
endmodule : can_engine_model

// >>> verification/testbench.sv
`timescale 1ns/100ps
`include "can_mbx_defs.svh"
module testbench;
  import can_mbx_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, init_mode;
  logic time_triggered_mode;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb, mbx_empty;
  logic [1:0] s_axi_bresp, s_axi_rresp, tx_sel, resp;
  stamp_cap_t stamp_cap;
  tx_info_t tx_info;
  filter_cfg_t [7:0] filter_cfg;
  logic [63:0] tx_data, e64;
  logic [7:0] cfg[4], mode[2], dat[8], d;
  logic [15:0] t;
  int failures, cmp_count, seed;
  can_mailbox_filter_config u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mbx_empty,
    .init_mode, .time_triggered_mode, .stamp_cap, .tx_sel, .tx_info,
    .filter_cfg, .tx_data);
  can_engine_model u_eng (.aclk, .mbx_empty, .stamp_cap);
  // Clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Write one byte, both channels offered together
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic aw_ok, w_ok;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Filter outputs against the stored config and mode bytes
  task automatic chk_flt();
    logic [7:0] n, m;
    for (int f = 0; f < 8; f++) begin
      n = cfg[f/2] >> (f % 2 * 4);
      m = mode[f/4] >> (f % 4 * 2);
      chk(64'(filter_cfg[f].fifo_select_bit), 64'(n[3]));
      chk(64'(filter_cfg[f].scale_field), 64'(n[2:1]));
      chk(64'(filter_cfg[f].filter_on_bit), 64'(n[0]));
      chk(64'(filter_cfg[f].high_half_mode), 64'(m[1]));
      chk(64'(filter_cfg[f].low_half_mode), 64'(m[0]));
    end
  endtask : chk_flt
  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    wrap_up();
  end
  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, time_triggered_mode} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_sel} = '0;
    s_axi_wstrb = 4'hf;
    init_mode = 1'b1;
    seed = 32'hdaea69ea;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(12'h200 + 12'(i * 4));
      chk(64'(rv), 64'h0);
    end
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      if (i < 4) cfg[i] = d;
      else mode[i-4] = d;
      wr(12'h200 + 12'(i * 4), d);
    end
    for (int i = 0; i < 6; i++) begin
      rd(12'h200 + 12'(i * 4));
      chk(64'(rv), 64'(i < 4 ? cfg[i] : mode[i-4]));
    end
    chk_flt();
    @(posedge aclk);
    init_mode <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      cfg[i] = (cfg[i] & 8'hee) | (d & 8'h11);
      wr(12'h200 + 12'(i * 4), d);
      rd(12'h200 + 12'(i * 4));
      chk(64'(rv), 64'(cfg[i]));
    end
    chk_flt();
    wr(12'h040, 8'hff);
    rd(12'h040);
    chk(64'(rv), 64'h8f);
    for (int b = 0; b < 8; b++) begin
      dat[b] = 8'($random(seed));
      wr(12'h044 + 12'(b * 4), dat[b]);
      e64[b*8 +: 8] = dat[b];
    end
    @(posedge aclk);
    tx_sel <= 2'h1;
    for (int b = 0; b < 8; b++) begin
      rd(12'h044 + 12'(b * 4));
      chk(64'(rv), 64'(dat[b]));
    end
    chk(tx_data, e64);
    chk(64'(tx_info.length_code), 64'hf);
    u_eng.set_empty(1, 1'b0);
    wr(12'h040, 8'h03);
    chk(64'(resp), 64'(`RESP_OKAY));
    wr(12'h044, ~dat[0]);
    rd(12'h040);
    chk(64'(rv), 64'h8f);
    rd(12'h044);
    chk(64'(rv), 64'(dat[0]));
    wr(12'h000, 8'h05);
    rd(12'h000);
    chk(64'(rv), 64'h0);
    // Bank writes: refused with the filter on, taken with it off
    cfg[0] = (cfg[0] & 8'hee) | 8'h01;
    wr(12'h200, 8'h01);
    d = 8'($random(seed));
    wr(12'h400, d);
    rd(12'h400);
    chk(64'(rv), 64'h0);
    wr(12'h420, d);
    rd(12'h420);
    chk(64'(rv), 64'(d));
    chk_flt();
    t = 16'($random(seed));
    u_eng.frame(2'h2, t);
    rd(12'h0a4);
    chk(64'(rv), 64'(t[7:0]));
    rd(12'h0a8);
    chk(64'(rv), 64'(t[15:8]));
    wr(12'h080, 8'h80);
    @(posedge aclk);
    tx_sel <= 2'h2;
    repeat (3) @(posedge aclk);
    chk(64'(tx_info.stamp), 64'(t));
    chk(64'(tx_info.send_global_time), 64'h0);
    time_triggered_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(64'(tx_info.send_global_time), 64'h1);
    rd(12'hffc);
    chk(64'(resp), 64'(`RESP_SLVERR));
    wrap_up();
  end
endmodule : testbench
